// [host_link_regs.vh]
// constants for the reader host link controller
// Behaviour
// - A zero interrupt status after identifier reception is handled as a corrupted identifier.
// - An interrupt status of 41 after any reception is handled as a corrupted reception.
// - On the serial link the clear-FIFO command is never sent ahead of request-handle.
// - Clear-FIFO follows the transmit-complete interrupt and precedes the handle reply.
// - The FIFO data register is never read right after line four falls.
// - A single-byte read of the FIFO status register comes before FIFO contents are read.
// - Clear-FIFO is sent before every query-repeat and query-adjust command.
// - Clear-FIFO is sent before the transmit commands 90, 91 and 92.
// - A single stop is a line seven change while the link clock is high, other lines stable.
// - FIFO contents are read only in continuous read mode.
`ifndef HOST_LINK_REGS_VH
`define HOST_LINK_REGS_VH
// timing
`define REF_CLK_KHZ 10000
`define LINK_HALF_NS 400
`define LINK_HALF_CYC ((`LINK_HALF_NS * `REF_CLK_KHZ) / 1000000)
// reader side addresses and commands
`define DEV_FIFO_DATA 8'h1F
`define DEV_FIFO_STAT 8'h1D
`define DEV_IRQ_STAT 8'h0C
`define DEV_MODE_READ 8'h40
`define DEV_MODE_CONT 8'h60
`define DCMD_CLEAR_FIFO 8'h8F
`define DCMD_REQ_HANDLE 8'h9F
`define DCMD_TX_A 8'h90
`define DCMD_TX_B 8'h91
`define DCMD_TX_C 8'h92
`define DCMD_QUERY_REP 8'h94
`define DCMD_QUERY_ADJ 8'h95
`define IRQ_VAL_ZERO 8'h00
`define IRQ_VAL_CORRUPT 8'h41
`define DEV_FIFO_DEPTH 24
// software register word offsets
`define OFS_CMD 4'h0
`define OFS_STATUS 4'h1
`define OFS_EVENTS 4'h2
`define OFS_MASK 4'h3
`define OFS_RXDATA 4'h4
`define OFS_CFG 4'h5
// command register fields
`define CMD_CODE_LSB 0
`define CMD_KIND_LSB 8
`define CMD_WDATA_LSB 16
`define CMD_LEN_LSB 24
`define KIND_DIRECT 2'h0
`define KIND_REG_WR 2'h1
`define KIND_REG_RD 2'h2
`define KIND_FIFO_RD 2'h3
// event bits
`define EV_DONE 0
`define EV_IRQ_READ 1
`define EV_RX_CORRUPT 2
`define EV_REFUSED 3
`define EV_WIDTH 4
`define RST_MASK 4'h0
`define RST_CFG 1'b0
`endif

// [serial_link_engine.v]
// serial link frame engine with clock divider
`timescale 1ns/1ps
`include "host_link_regs.vh"
module serial_link_engine (
   input wire ref_clk_i,
   input wire rst_n_i,
   input wire start_i,
   input wire [7:0] hdr_i,
   input wire wr_i,
   input wire [7:0] wdata_i,
   input wire [4:0] len_i,
   output wire busy_o,
   output reg done_o,
   output reg [7:0] rbyte_o,
   output reg rvalid_o,
   output reg sclk_o,
   output reg sen_o,
   output reg mosi_o,
   input wire miso_i
);
   localparam ST_IDLE = 3'h0;
   localparam ST_SETUP = 3'h1;
   localparam ST_LOW = 3'h2;
   localparam ST_HIGH = 3'h3;
   localparam ST_TAIL = 3'h4;
   reg [2:0] st_q;
   reg [7:0] cnt_q;
   reg [7:0] sh_q;
   reg [7:0] rsh_q;
   reg [2:0] bit_q;
   reg [4:0] byte_q;
   reg [4:0] len_q;
   reg wr_q;
   reg [7:0] wd_q;
   reg miso_m_q;
   reg miso_s_q;
   wire tick;
   wire [7:0] rnext;
   assign tick = (cnt_q == `LINK_HALF_CYC - 1);
   assign busy_o = (st_q != ST_IDLE);
   assign rnext = {rsh_q[6:0], miso_s_q};
   always @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         miso_m_q <= 1'b0;
         miso_s_q <= 1'b0;
      end else begin
         miso_m_q <= miso_i;
         miso_s_q <= miso_m_q;
      end
   end
   always @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_q <= ST_IDLE;
         cnt_q <= 8'h00;
         sh_q <= 8'h00;
         rsh_q <= 8'h00;
         bit_q <= 3'h0;
         byte_q <= 5'h00;
         len_q <= 5'h00;
         wr_q <= 1'b0;
         wd_q <= 8'h00;
         done_o <= 1'b0;
         rbyte_o <= 8'h00;
         rvalid_o <= 1'b0;
         sclk_o <= 1'b0;
         sen_o <= 1'b0;
         mosi_o <= 1'b0;
      end else begin
         done_o <= 1'b0;
         rvalid_o <= 1'b0;
         cnt_q <= (st_q == ST_IDLE || tick) ? 8'h00 : cnt_q + 8'h01;
         case (st_q)
            ST_IDLE: begin
               if (start_i) begin
                  sh_q <= hdr_i;
                  wr_q <= wr_i;
                  wd_q <= wdata_i;
                  len_q <= len_i;
                  bit_q <= 3'h0;
                  byte_q <= 5'h00;
                  sen_o <= 1'b1;
                  st_q <= ST_SETUP;
               end
            end
            ST_SETUP: begin
               if (tick) begin
                  mosi_o <= sh_q[7];
                  st_q <= ST_LOW;
               end
            end
            ST_LOW: begin
               if (tick) begin
                  sclk_o <= 1'b1;
                  st_q <= ST_HIGH;
               end
            end
            ST_HIGH: begin
               if (tick) begin
                  sclk_o <= 1'b0;
                  rsh_q <= rnext;
                  if (bit_q == 3'h7) begin
                     if (byte_q != 5'h00 && !wr_q) begin
                        rbyte_o <= rnext;
                        rvalid_o <= 1'b1;
                     end
                     if (byte_q == len_q) begin
                        mosi_o <= 1'b0;
                        st_q <= ST_TAIL;
                     end else begin
                        byte_q <= byte_q + 5'h01;
                        bit_q <= 3'h0;
                        sh_q <= wr_q ? wd_q : 8'h00;
                        mosi_o <= wr_q ? wd_q[7] : 1'b0;
                        st_q <= ST_LOW;
                     end
                  end else begin
                     bit_q <= bit_q + 3'h1;
                     sh_q <= {sh_q[6:0], 1'b0};
                     mosi_o <= sh_q[6];
                     st_q <= ST_LOW;
                  end
               end
            end
            ST_TAIL: begin
               if (tick) begin
                  sen_o <= 1'b0;
                  done_o <= 1'b1;
                  st_q <= ST_IDLE;
               end
            end
            default: st_q <= ST_IDLE;
         endcase
      end
   end
endmodule // serial_link_engine

// [parallel_link_engine.v]
// parallel link frame engine with start and single stop
`timescale 1ns/1ps
`include "host_link_regs.vh"
module parallel_link_engine (
   input wire ref_clk_i,
   input wire rst_n_i,
   input wire start_i,
   input wire [7:0] hdr_i,
   input wire wr_i,
   input wire [7:0] wdata_i,
   input wire [4:0] len_i,
   output wire busy_o,
   output reg done_o,
   output reg [7:0] rbyte_o,
   output reg rvalid_o,
   output reg pclk_o,
   output reg [7:0] io_o,
   output reg [7:0] io_oe_o,
   input wire [7:0] io_i
);
   localparam ST_IDLE = 3'h0;
   localparam ST_S0 = 3'h1;
   localparam ST_S1 = 3'h2;
   localparam ST_B0 = 3'h3;
   localparam ST_B1 = 3'h4;
   localparam ST_P0 = 3'h5;
   localparam ST_P1 = 3'h6;
   localparam ST_P2 = 3'h7;
   reg [2:0] st_q;
   reg [7:0] cnt_q;
   reg [4:0] byte_q;
   reg [4:0] len_q;
   reg wr_q;
   reg [7:0] wd_q;
   reg [7:0] io_m_q;
   reg [7:0] io_s_q;
   wire tick;
   wire rd_byte;
   assign tick = (cnt_q == `LINK_HALF_CYC - 1);
   assign busy_o = (st_q != ST_IDLE);
   assign rd_byte = (byte_q != 5'h00) && !wr_q;
   always @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         io_m_q <= 8'h00;
         io_s_q <= 8'h00;
      end else begin
         io_m_q <= io_i;
         io_s_q <= io_m_q;
      end
   end
   always @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_q <= ST_IDLE;
         cnt_q <= 8'h00;
         byte_q <= 5'h00;
         len_q <= 5'h00;
         wr_q <= 1'b0;
         wd_q <= 8'h00;
         done_o <= 1'b0;
         rbyte_o <= 8'h00;
         rvalid_o <= 1'b0;
         pclk_o <= 1'b0;
         io_o <= 8'h00;
         io_oe_o <= 8'h00;
      end else begin
         done_o <= 1'b0;
         rvalid_o <= 1'b0;
         cnt_q <= (st_q == ST_IDLE || tick) ? 8'h00 : cnt_q + 8'h01;
         case (st_q)
            ST_IDLE: begin
               if (start_i) begin
                  wr_q <= wr_i;
                  wd_q <= wdata_i;
                  len_q <= len_i;
                  byte_q <= 5'h00;
                  io_o <= 8'h00;
                  io_oe_o <= 8'hFF;
                  st_q <= ST_S0;
               end
            end
            ST_S0: begin
               if (tick) begin
                  pclk_o <= 1'b1;
                  st_q <= ST_S1;
               end
            end
            ST_S1: begin
               // start: line seven rises while clock high
               if (tick) begin
                  io_o <= 8'h80;
                  st_q <= ST_B0;
               end
            end
            ST_B0: begin
               if (tick) begin
                  pclk_o <= 1'b0;
                  io_o <= (byte_q == 5'h00) ? hdr_i : wd_q;
                  io_oe_o <= rd_byte ? 8'h00 : 8'hFF;
                  st_q <= ST_B1;
               end
            end
            ST_B1: begin
               if (tick) begin
                  pclk_o <= 1'b1;
                  st_q <= ST_P0;
               end
            end
            ST_P0: begin
               if (tick) begin
                  if (rd_byte) begin
                     rbyte_o <= io_s_q;
                     rvalid_o <= 1'b1;
                  end
                  pclk_o <= 1'b0;
                  if (byte_q == len_q) begin
                     io_o <= 8'h80;
                     io_oe_o <= 8'hFF;
                     st_q <= ST_P1;
                  end else begin
                     byte_q <= byte_q + 5'h01;
                     st_q <= ST_B0;
                  end
               end
            end
            ST_P1: begin
               if (tick) begin
                  pclk_o <= 1'b1;
                  st_q <= ST_P2;
               end
            end
            ST_P2: begin
               // single stop: line seven falls, low seven held
               if (tick) begin
                  if (io_o[7]) begin
                     io_o <= 8'h00;
                  end else begin
                     pclk_o <= 1'b0;
                     io_oe_o <= 8'h00;
                     done_o <= 1'b1;
                     st_q <= ST_IDLE;
                  end
               end
            end
            default: st_q <= ST_IDLE;
         endcase
      end
   end
endmodule // parallel_link_engine

// [reader_link_controller.v]
// host controller sequencing reader commands and FIFO reads
//
// Our own choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "host_link_regs.vh"
module reader_link_controller (
   input wire ref_clk_i,
   input wire rst_n_i,
   input wire [3:0] avs_address_i,
   input wire avs_read_i,
   input wire avs_write_i,
   input wire [31:0] avs_writedata_i,
   output reg [31:0] avs_readdata_o,
   output wire avs_waitrequest_o,
   output wire irq_o,
   input wire dev_irq_i,
   output wire sclk_o,
   output wire sen_o,
   output wire mosi_o,
   input wire miso_i,
   output wire pclk_o,
   output wire [7:0] io_o,
   output wire [7:0] io_oe_o,
   input wire [7:0] io_i
);
   localparam ST_IDLE = 4'h0;
   localparam ST_PRE = 4'h1;
   localparam ST_CMD = 4'h2;
   localparam ST_TXW = 4'h3;
   localparam ST_POST = 4'h4;
   localparam ST_ISR = 4'h5;
   localparam ST_FST = 4'h6;
   localparam ST_FRD = 4'h7;
   localparam ST_REG = 4'h8;
   reg [3:0] st_q;
   reg [3:0] st_d;
   reg issued_q;
   reg [7:0] code_q;
   reg [1:0] kind_q;
   reg [7:0] wdata_q;
   reg [4:0] len_q;
   reg par_q;
   reg [3:0] mask_q;
   reg [3:0] ev_q;
   reg [3:0] ev_set;
   reg [7:0] irq_val_q;
   reg [7:0] fstat_q;
   reg [7:0] reg_val_q;
   reg [7:0] rx_mem [0:`DEV_FIFO_DEPTH-1];
   reg [4:0] rx_wp_q;
   reg [4:0] rx_rp_q;
   reg [4:0] rx_cnt_q;
   reg ack_q;
   reg irq_m_q;
   reg irq_s_q;
   reg irq_p_q;
   reg irq_pend_q;
   reg eng_start;
   reg [7:0] eng_hdr;
   reg eng_wr;
   reg [4:0] eng_len;
   wire req;
   wire acc;
   wire irq_rise;
   wire idle;
   wire needs_clear;
   wire ser_busy;
   wire ser_done;
   wire [7:0] ser_byte;
   wire ser_valid;
   wire par_busy;
   wire par_done;
   wire [7:0] par_byte;
   wire par_valid;
   wire eng_done;
   wire [7:0] eng_byte;
   wire eng_valid;
   wire cmd_wr;
   wire ev_rd;
   wire rx_pop;
   wire [4:0] flen;
   assign req = avs_read_i | avs_write_i;
   assign avs_waitrequest_o = req & ~ack_q;
   assign acc = req & ack_q;
   assign irq_o = |(ev_q & mask_q);
   assign irq_rise = irq_s_q & ~irq_p_q;
   assign idle = (st_q == ST_IDLE);
   assign eng_done = par_q ? par_done : ser_done;
   assign eng_byte = par_q ? par_byte : ser_byte;
   assign eng_valid = par_q ? par_valid : ser_valid;
   assign cmd_wr = acc & avs_write_i & (avs_address_i == `OFS_CMD);
   assign ev_rd = acc & avs_read_i & (avs_address_i == `OFS_EVENTS);
   assign rx_pop = acc & avs_read_i & (avs_address_i == `OFS_RXDATA) & (rx_cnt_q != 5'h00);
   assign flen = (avs_writedata_i[`CMD_LEN_LSB+4:`CMD_LEN_LSB] > `DEV_FIFO_DEPTH) ?
      5'd24 : avs_writedata_i[`CMD_LEN_LSB+4:`CMD_LEN_LSB];
   assign needs_clear = (avs_writedata_i[7:0] == `DCMD_TX_A) ||
      (avs_writedata_i[7:0] == `DCMD_TX_B) || (avs_writedata_i[7:0] == `DCMD_TX_C) ||
      (avs_writedata_i[7:0] == `DCMD_QUERY_REP) || (avs_writedata_i[7:0] == `DCMD_QUERY_ADJ);
   serial_link_engine u_ser (
      .ref_clk_i(ref_clk_i),
      .rst_n_i(rst_n_i),
      .start_i(eng_start & ~par_q),
      .hdr_i(eng_hdr),
      .wr_i(eng_wr),
      .wdata_i(wdata_q),
      .len_i(eng_len),
      .busy_o(ser_busy),
      .done_o(ser_done),
      .rbyte_o(ser_byte),
      .rvalid_o(ser_valid),
      .sclk_o(sclk_o),
      .sen_o(sen_o),
      .mosi_o(mosi_o),
      .miso_i(miso_i)
   );
   parallel_link_engine u_par (
      .ref_clk_i(ref_clk_i),
      .rst_n_i(rst_n_i),
      .start_i(eng_start & par_q),
      .hdr_i(eng_hdr),
      .wr_i(eng_wr),
      .wdata_i(wdata_q),
      .len_i(eng_len),
      .busy_o(par_busy),
      .done_o(par_done),
      .rbyte_o(par_byte),
      .rvalid_o(par_valid),
      .pclk_o(pclk_o),
      .io_o(io_o),
      .io_oe_o(io_oe_o),
      .io_i(io_i)
   );
   // frame request for the current state
   always @* begin
      eng_start = (st_q != ST_IDLE) && (st_q != ST_TXW) && !issued_q &&
         !ser_busy && !par_busy;
      eng_hdr = `DCMD_CLEAR_FIFO;
      eng_wr = 1'b0;
      eng_len = 5'h00;
      case (st_q)
         ST_CMD: eng_hdr = code_q;
         ST_ISR: begin
            eng_hdr = `DEV_MODE_READ | `DEV_IRQ_STAT;
            eng_len = 5'h01;
         end
         ST_FST: begin
            eng_hdr = `DEV_MODE_READ | `DEV_FIFO_STAT;
            eng_len = 5'h01;
         end
         ST_FRD: begin
            eng_hdr = `DEV_MODE_CONT | `DEV_FIFO_DATA;
            eng_len = len_q;
         end
         ST_REG: begin
            eng_hdr = (kind_q == `KIND_REG_WR) ? code_q : (`DEV_MODE_READ | code_q);
            eng_wr = (kind_q == `KIND_REG_WR);
            eng_len = 5'h01;
         end
         default: eng_hdr = `DCMD_CLEAR_FIFO;
      endcase
   end
   // sequencer next state
   always @* begin
      st_d = st_q;
      case (st_q)
         ST_IDLE: begin
            if (cmd_wr) begin
               case (avs_writedata_i[`CMD_KIND_LSB+1:`CMD_KIND_LSB])
                  `KIND_DIRECT: st_d = needs_clear ? ST_PRE : ST_CMD;
                  `KIND_FIFO_RD: st_d = ST_FST;
                  default: st_d = ST_REG;
               endcase
            end else if (irq_pend_q) begin
               st_d = ST_ISR;
            end
         end
         ST_PRE: if (eng_done) st_d = ST_CMD;
         // request-handle goes out with no clear ahead
         ST_CMD: if (eng_done) st_d = (code_q == `DCMD_REQ_HANDLE) ? ST_TXW : ST_IDLE;
         ST_TXW: if (irq_pend_q) st_d = ST_POST;
         ST_POST: if (eng_done) st_d = ST_IDLE;
         ST_ISR: if (eng_done) st_d = ST_IDLE;
         ST_FST: if (eng_done) st_d = (len_q == 5'h00) ? ST_IDLE : ST_FRD;
         ST_FRD: if (eng_done) st_d = ST_IDLE;
         ST_REG: if (eng_done) st_d = ST_IDLE;
         default: st_d = ST_IDLE;
      endcase
   end
   // event sources
   always @* begin
      ev_set = 4'h0;
      ev_set[`EV_DONE] = eng_done && (st_d == ST_IDLE) && (st_q != ST_ISR);
      ev_set[`EV_IRQ_READ] = eng_done && (st_q == ST_ISR);
      // zero or 41 taken as corrupted reception
      ev_set[`EV_RX_CORRUPT] = eng_valid && (st_q == ST_ISR) &&
         ((eng_byte == `IRQ_VAL_ZERO) || (eng_byte == `IRQ_VAL_CORRUPT));
      ev_set[`EV_REFUSED] = acc & avs_write_i & (avs_address_i == `OFS_CMD) & ~idle;
   end
   always @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         irq_m_q <= 1'b0;
         irq_s_q <= 1'b0;
         irq_p_q <= 1'b0;
      end else begin
         irq_m_q <= dev_irq_i;
         irq_s_q <= irq_m_q;
         irq_p_q <= irq_s_q;
      end
   end
   always @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_q <= ST_IDLE;
         issued_q <= 1'b0;
         code_q <= 8'h00;
         kind_q <= `KIND_DIRECT;
         wdata_q <= 8'h00;
         len_q <= 5'h00;
         par_q <= `RST_CFG;
         mask_q <= `RST_MASK;
         ev_q <= 4'h0;
         irq_val_q <= 8'h00;
         fstat_q <= 8'h00;
         reg_val_q <= 8'h00;
         rx_wp_q <= 5'h00;
         rx_rp_q <= 5'h00;
         rx_cnt_q <= 5'h00;
         irq_pend_q <= 1'b0;
         ack_q <= 1'b0;
         avs_readdata_o <= 32'h0000_0000;
      end else begin
         st_q <= st_d;
         ack_q <= req & ~ack_q;
         if (st_d != st_q) begin
            issued_q <= 1'b0;
         end else if (eng_start) begin
            issued_q <= 1'b1;
         end
         // interrupt edge held until consumed, new edge wins
         if (irq_rise) begin
            irq_pend_q <= 1'b1;
         end else if ((st_q == ST_TXW) || (idle && !cmd_wr && st_d == ST_ISR)) begin
            irq_pend_q <= 1'b0;
         end
         if (cmd_wr && idle) begin
            code_q <= avs_writedata_i[`CMD_CODE_LSB+7:`CMD_CODE_LSB];
            kind_q <= avs_writedata_i[`CMD_KIND_LSB+1:`CMD_KIND_LSB];
            wdata_q <= avs_writedata_i[`CMD_WDATA_LSB+7:`CMD_WDATA_LSB];
            len_q <= flen;
            if (avs_writedata_i[`CMD_KIND_LSB+1:`CMD_KIND_LSB] == `KIND_FIFO_RD) begin
               rx_wp_q <= 5'h00;
               rx_rp_q <= 5'h00;
               rx_cnt_q <= 5'h00;
            end
         end else begin
            if (eng_valid && st_q == ST_FRD && rx_cnt_q != `DEV_FIFO_DEPTH) begin
               rx_mem[rx_wp_q] <= eng_byte;
               rx_wp_q <= rx_wp_q + 5'h01;
            end
            if (rx_pop) begin
               rx_rp_q <= rx_rp_q + 5'h01;
            end
            rx_cnt_q <= rx_cnt_q + {4'h0, eng_valid && st_q == ST_FRD &&
               rx_cnt_q != `DEV_FIFO_DEPTH} - {4'h0, rx_pop};
         end
         if (eng_valid && st_q == ST_ISR) begin
            irq_val_q <= eng_byte;
         end
         if (eng_valid && st_q == ST_FST) begin
            fstat_q <= eng_byte;
         end
         if (eng_valid && st_q == ST_REG) begin
            reg_val_q <= eng_byte;
         end
         if (acc && avs_write_i && avs_address_i == `OFS_MASK) begin
            mask_q <= avs_writedata_i[`EV_WIDTH-1:0];
         end
         if (acc && avs_write_i && avs_address_i == `OFS_CFG && idle) begin
            par_q <= avs_writedata_i[0];
         end
         // read clears, a new event in that cycle survives
         ev_q <= (ev_rd ? 4'h0 : ev_q) | ev_set;
         if (req && !ack_q) begin
            case (avs_address_i)
               `OFS_CMD: avs_readdata_o <= {3'h0, len_q, wdata_q, 6'h00, kind_q, code_q};
               `OFS_STATUS: avs_readdata_o <= {fstat_q, 3'h0, rx_cnt_q, irq_val_q,
                  reg_val_q[6:0], ~idle};
               `OFS_EVENTS: avs_readdata_o <= {28'h0000000, ev_q};
               `OFS_MASK: avs_readdata_o <= {28'h0000000, mask_q};
               `OFS_RXDATA: avs_readdata_o <= {24'h000000, rx_mem[rx_rp_q]};
               `OFS_CFG: avs_readdata_o <= {reg_val_q, 23'h000000, par_q};
               default: avs_readdata_o <= 32'h0000_0000;
            endcase
         end
      end
   end
endmodule // reader_link_controller

// [link_checker_properties.sv]
// port assertions for the reader link controller
`timescale 1ns/1ps
module link_checker (
   input wire ref_clk_i,
   input wire rst_n_i,
   input wire avs_read_i,
   input wire avs_write_i,
   input wire avs_waitrequest_o,
   input wire sclk_o,
   input wire sen_o,
   input wire mosi_o,
   input wire pclk_o,
   input wire [7:0] io_o,
   input wire [7:0] io_oe_o
);
   default clocking dc @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);
   logic sclk_q, hv_q;
   logic [3:0] nb_q;
   logic [7:0] sh_q, hdr_q, prv_q;
   // first byte of each serial frame
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         {sclk_q, hv_q, nb_q, sh_q, hdr_q, prv_q} <= '0;
      end else begin
         sclk_q <= sclk_o;
         hv_q <= 1'b0;
         if (!sen_o) begin
            nb_q <= 4'h0;
         end else if (sclk_o && !sclk_q) begin
            sh_q <= {sh_q[6:0], mosi_o};
            nb_q <= nb_q + {3'h0, nb_q != 4'hF};
            if (nb_q == 4'h7) begin
               prv_q <= hdr_q;
               hdr_q <= {sh_q[6:0], mosi_o};
               hv_q <= 1'b1;
            end
         end
      end
   end
   a_wait_once: assert property ($rose(avs_read_i || avs_write_i) |->
      avs_waitrequest_o ##1 !avs_waitrequest_o) else $error("wait state count");
   a_sclk_idle: assert property (!sen_o |-> !sclk_o) else $error("clock outside frame");
   a_sclk_half: assert property ($rose(sclk_o) |-> sclk_o[*4] ##1 !sclk_o)
      else $error("clock half period");
   a_mosi_hold: assert property (sclk_o && $past(sclk_o) |-> $stable(mosi_o))
      else $error("data moved in clock high");
   a_clr_tx: assert property (hv_q && hdr_q inside {8'h90, 8'h91, 8'h92}
      |-> prv_q == 8'h8F) else $error("transmit without clear");
   a_clr_query: assert property (hv_q && hdr_q inside {8'h94, 8'h95}
      |-> prv_q == 8'h8F) else $error("query without clear");
   a_no_clr_first: assert property (hv_q && hdr_q == 8'h9F
      |-> prv_q != 8'h8F) else $error("clear ahead of handle request");
   a_stat_first: assert property (hv_q && hdr_q == 8'h7F
      |-> prv_q == 8'h5D) else $error("fifo read without status");
   a_stop_still: assert property (pclk_o && $past(pclk_o) && &io_oe_o && &$past(io_oe_o)
      |-> io_o[6:0] == $past(io_o[6:0])) else $error("low lines moved in clock high");
endmodule // link_checker
bind reader_link_controller link_checker i_chk (.*);

// [reader_model.sv]
// serial reader device model
`timescale 1ns/1ps
module reader_model (
   input wire sclk_i,
   input wire sen_i,
   input wire mosi_i,
   input wire [7:0] irq_val_i,
   output logic miso_o,
   output logic irq_o
);
   logic [7:0] sh, tx, hdr;
   logic [7:0] hlog [0:63];
   int nb, nh, cnt;
   initial begin
      miso_o = 1'b0;
      irq_o = 1'b0;
      nh = 0;
      cnt = 24;
   end
   always @(posedge sen_i) nb = 0;
   always @(posedge sclk_i) begin
      if (sen_i && ++nb <= 8) begin
         sh = {sh[6:0], mosi_i};
         if (nb == 8) begin
            hdr = sh;
            hlog[nh[5:0]] = sh;
            nh++;
            if (sh == 8'h8F) cnt = 0;
            tx = (sh == 8'h4C) ? irq_val_i : (sh == 8'h5D) ? cnt[7:0] : 8'hA5;
         end
      end
   end
   always @(negedge sclk_i) begin
      if (sen_i && nb >= 8) begin
         miso_o = tx[7];
         tx = {tx[6:0], tx[7]};
      end
   end
   // released line inverts, handle reply later
   always @(negedge sen_i) begin
      miso_o = ~miso_o;
      if (hdr == 8'h9F) begin
         #3020 irq_o = 1'b1;
         #1000 irq_o = 1'b0;
      end
   end
   task pulse;
      #20 irq_o = 1'b1;
      #1000 irq_o = 1'b0;
   endtask
endmodule // reader_model

// [tb.sv]
// testbench for the reader link controller
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_errors++; \
   $display("BAD %0t got %h want %h", $time, a, b); end end
module tb;
   logic ref_clk_i, rst_n_i, avs_read_i, avs_write_i;
   logic [3:0] avs_address_i;
   logic [31:0] avs_writedata_i, q, s, r;
   logic [7:0] iv;
   logic [4:0] ln;
   wire [7:0] io_i, io_o, io_oe_o;
   wire [31:0] avs_readdata_o;
   wire avs_waitrequest_o, irq_o, dev_irq_i, sclk_o, sen_o, mosi_o, miso_i, pclk_o;
   int n_errors, n_tests, k, m, j, n0;
   logic [7:0] cl [0:5] = '{8'h90, 8'h91, 8'h92, 8'h94, 8'h95, 8'h9F};
   logic [7:0] vl [0:2] = '{8'h00, 8'h41, 8'h80};
   assign io_i = io_o ^ ~io_oe_o;
   reader_link_controller i_dut (.*);
   reader_model i_model (.sclk_i(sclk_o), .sen_i(sen_o), .mosi_i(mosi_o),
      .irq_val_i(iv), .miso_o(miso_i), .irq_o(dev_irq_i));
   logic pc_q, p7_q;
   int n_stop;
   always @(posedge ref_clk_i) begin
      pc_q <= pclk_o;
      p7_q <= io_o[7];
      if (pclk_o && pc_q && p7_q && !io_o[7] && io_oe_o == 8'hFF) n_stop++;
   end
   function logic [31:0] nx(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   task complete_run;
      $display("tests %0d errors %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task fail;
      n_errors++;
      complete_run;
   endtask
   task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      avs_address_i <= a;
      avs_writedata_i <= d;
      avs_write_i <= w;
      avs_read_i <= !w;
      k = 0;
      do begin
         @(posedge ref_clk_i);
         k++;
      end while (avs_waitrequest_o !== 1'b0 && k < 40);
      q = avs_readdata_o;
      avs_write_i <= 1'b0;
      avs_read_i <= 1'b0;
      if (k >= 40) fail;
      @(posedge ref_clk_i);
   endtask
   task idle;
      s = 32'h1;
      for (m = 0; m < 3000 && s[0] !== 1'b0; m++) begin
         bus(0, 4'h1, 0);
         s = q;
      end
      if (m >= 3000) fail;
   endtask
   initial begin
      ref_clk_i = 1'b0;
      forever #50 ref_clk_i = ~ref_clk_i;
   end
   initial begin
      {rst_n_i, avs_read_i, avs_write_i, avs_address_i, avs_writedata_i} = '0;
      iv = 8'h00;
      r = 32'hE27AAB2E;
      repeat (4) @(posedge ref_clk_i);
      rst_n_i <= 1'b1;
      @(posedge ref_clk_i);
      bus(0, 4'h3, 0);
      `CHK(q[3:0], 4'h0)
      bus(0, 4'h5, 0);
      `CHK(q[0], 1'b0)
      bus(0, 4'hF, 0);
      `CHK(q, 32'h0)
      r = nx(r);
      bus(1, 4'h3, r);
      bus(0, 4'h3, 0);
      `CHK(q[3:0], r[3:0])
      foreach (cl[i]) begin
         n0 = i_model.nh;
         bus(1, 4'h0, {24'h0, cl[i]});
         idle;
         `CHK(i_model.hlog[n0], (cl[i] == 8'h9F) ? cl[i] : 8'h8F)
         `CHK(i_model.hlog[n0 + 1], (cl[i] == 8'h9F) ? 8'h8F : cl[i])
      end
      repeat (3) begin
         r = nx(r);
         ln = r[4:0] % 5'd24 + 5'd1;
         n0 = i_model.nh;
         bus(1, 4'h0, {3'h0, ln, 14'h0, 2'h3, 8'h1F});
         bus(1, 4'h0, 32'h8F);
         idle;
         `CHK(i_model.hlog[n0], 8'h5D)
         `CHK(i_model.hlog[n0 + 1], 8'h7F)
         bus(0, 4'h1, 0);
         `CHK(q[31:24], 8'h00)
         `CHK(q[20:16], ln)
         for (j = 0; j < ln; j++) begin
            bus(0, 4'h4, 0);
            `CHK(q[7:0], 8'hA5)
         end
         bus(0, 4'h2, 0);
         `CHK(q[3], 1'b1)
      end
      foreach (vl[i]) begin
         iv <= vl[i];
         bus(1, 4'h3, 32'h6);
         i_model.pulse;
         @(posedge ref_clk_i);
         for (m = 0; m < 300 && irq_o !== 1'b1; m++) @(posedge ref_clk_i);
         if (m >= 300) fail;
         bus(1, 4'h3, 32'h0);
         `CHK(irq_o, 1'b0)
         bus(0, 4'h2, 0);
         `CHK(q[2:1], {vl[i] != 8'h80, 1'b1})
         bus(0, 4'h1, 0);
         `CHK(q[15:8], vl[i])
      end
      n0 = i_model.nh;
      bus(1, 4'h0, 32'h00AB_0105);
      idle;
      bus(1, 4'h0, 32'h0000_0207);
      idle;
      `CHK(i_model.hlog[n0], 8'h05)
      `CHK(i_model.hlog[n0 + 1], 8'h47)
      bus(0, 4'h5, 0);
      `CHK(q[31:24], 8'hA5)
      bus(1, 4'h5, 32'h1);
      bus(1, 4'h0, 32'h8F);
      idle;
      bus(0, 4'h2, 0);
      `CHK(q[0], 1'b1)
      `CHK(n_stop, 1)
      complete_run;
   end
endmodule // tb
